// [src/ccf_pkg.sv]
package ccf_pkg;

    // ********************************************************
    // Word layout
    // ********************************************************
    localparam int CCF_WIDTH = 18;
    localparam int CCF_DEPTH_DEF = 512;
    localparam int CCF_LO_LSB = 0;
    localparam int CCF_LO_MSB = 7;
    localparam int CCF_PAR_LO = 8;
    localparam int CCF_HI_LSB = 9;
    localparam int CCF_HI_MSB = 16;
    localparam int CCF_PAR_HI = 17;

    // ********************************************************
    // Programming register
    // ********************************************************
    localparam int CCF_OFS_W = 16;
    localparam logic [CCF_OFS_W-1:0] CCF_OFS_RST = 16'h0008;

    typedef enum logic [1:0] {
        CCF_PAR_OFF,
        CCF_PAR_GEN,
        CCF_PAR_CHK,
        CCF_PAR_RSVD
    } ccf_par_mode_t;

    typedef struct packed {
        ccf_par_mode_t mode;
        logic [CCF_OFS_W-1:0] ofs;
    } ccf_prog_t;

    localparam ccf_prog_t CCF_PROG_RST = '{mode: CCF_PAR_OFF, ofs: CCF_OFS_RST};

endpackage

// [src/ccf_store.sv]
`timescale 1ns/1ps

// ********************************************************
// Flip-flop storage array, one write and one read port
// ********************************************************
module ccf_store #(
    parameter int W = ccf_pkg::CCF_WIDTH,
    parameter int DEPTH = ccf_pkg::CCF_DEPTH_DEF,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic ref_clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [W-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [W-1:0] rdata
);

    logic [W-1:0] mem_q [DEPTH];

    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        wire entry_we = we && (waddr == AW'(i));
        always_ff @(posedge ref_clk) begin
            if (entry_we) begin
                mem_q[i] <= wdata;
            end
        end
    end

    assign rdata = mem_q[raddr];

endmodule // ccf_store

// [src/ccf_fifo.sv]
`timescale 1ns/1ps

// Notes on behaviour
// - Words are eighteen bits in and out
// - Depth parameter: 512, 1024 or 2048
// - Retransmit low replays written data standalone
// - Write clock rise with enable stores word
// - Held write enable writes every write cycle
// - Read clock rise with enable outputs word
// - Works with common or unrelated clocks
// - Reads and writes may happen simultaneously
// - Cascade output signals next device activation
// - Three status pins encode six states
// - Almost flag shares cascade output pin
// - Empty and almost empty change on reads
// - Half, almost full, full change on writes
// - Flags hold at least one clock
// - Full buffer ignores writes
// - Empty buffer ignores reads
// - Program mode writes go to program register
// - Parity generation replaces bits 8 and 17
module ccf_fifo #(
    parameter int DEPTH = ccf_pkg::CCF_DEPTH_DEF
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic write_clock,
    input wire logic write_enable_n,
    input wire logic [ccf_pkg::CCF_WIDTH-1:0] data_in,
    input wire logic read_clock,
    input wire logic read_enable_n,
    input wire logic output_enable_n,
    input wire logic reset_program_n,
    input wire logic retransmit_n,
    input wire logic first_load_n,
    input wire logic cascade_in_n,
    input wire logic cascade_en,
    output logic [ccf_pkg::CCF_WIDTH-1:0] data_out,
    output logic data_oe,
    output logic empty_full_n,
    output logic half_full_flag,
    output logic almost_flag_cascade_out_n
);

    localparam int AW = $clog2(DEPTH);
    localparam int W = ccf_pkg::CCF_WIDTH;
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    localparam logic [AW:0] HALF_CNT = (AW+1)'(DEPTH / 2);
    localparam logic [AW:0] ONE = (AW+1)'(1);

    // ********************************************************
    // Clock edge and strobe decode
    // ********************************************************
    logic wclk_q;
    logic rclk_q;
    logic xi_q;
    logic [AW:0] wptr_q, wptr_d, rptr_q, rptr_d;
    logic empty_q, empty_d, ae_q, ae_d;
    logic full_q, full_d, af_q, af_d, hf_d;
    logic wtok_q, wtok_d, rtok_q, rtok_d;
    ccf_pkg::ccf_prog_t prog_q;
    logic [W-1:0] dout_d;
    logic [W-1:0] mem_rdata;
    logic [W-1:0] wdata;
    logic [W-1:0] rd_word;

    wire prog_mode = ~reset_program_n;
    wire wr_edge = write_clock & ~wclk_q;
    wire rd_edge = read_clock & ~rclk_q;
    wire wr_req = wr_edge & ~write_enable_n;
    wire rd_req = rd_edge & ~read_enable_n;
    wire prog_wr = wr_req & prog_mode;
    wire prog_rd = rd_req & prog_mode;
    wire wr_do = wr_req & ~prog_mode & ~full_q & wtok_q;
    wire rt_do = rd_edge & ~retransmit_n & ~cascade_en & ~prog_mode;
    wire rd_do = rd_req & ~prog_mode & ~empty_q & rtok_q & retransmit_n;
    wire xi_fall = ~cascade_in_n & xi_q;

    // ********************************************************
    // Pointers and fill count
    // ********************************************************
    wire [AW:0] cnt = wptr_q - rptr_q;
    wire [AW:0] cnt_nx = wptr_d - rptr_d;
    wire [AW:0] ofs_cnt = prog_q.ofs[AW:0];
    wire [AW+1:0] af_sum = {1'b0, cnt_nx} + {1'b0, ofs_cnt};

    assign wptr_d = prog_mode ? '0 : (wr_do ? wptr_q + ONE : wptr_q);
    // Rewind on retransmit; write side is left alone
    assign rptr_d = (prog_mode | rt_do) ? '0 : (rd_do ? rptr_q + ONE : rptr_q);

    // ********************************************************
    // Flags, each owned by one port's clock
    // ********************************************************
    assign empty_d = prog_mode ? 1'b1 : (rd_edge ? (cnt_nx == '0) : empty_q);
    assign ae_d = prog_mode ? 1'b1 : (rd_edge ? (cnt_nx <= ofs_cnt) : ae_q);
    assign full_d = prog_mode ? 1'b0 : (wr_edge ? (cnt_nx == FULL_CNT) : full_q);
    assign af_d = prog_mode ? 1'b0 : (wr_edge ? (af_sum >= {1'b0, FULL_CNT}) : af_q);
    assign hf_d = prog_mode ? 1'b0 : (wr_edge ? (cnt_nx > HALF_CNT) : half_full_flag);

    // ********************************************************
    // Depth cascade token ring
    // ********************************************************
    wire start_tok = cascade_en ? ~first_load_n : 1'b1;
    wire pass_w = cascade_en & wr_do & (cnt_nx == FULL_CNT);
    wire pass_r = cascade_en & rd_do & (cnt_nx == '0) & ~wtok_q;
    wire grant_w = cascade_en & xi_fall & ~wtok_q & ~rtok_q & (cnt == '0);
    wire grant_r = cascade_en & xi_fall & ~rtok_q & (cnt != '0);

    assign wtok_d = prog_mode ? start_tok : (pass_w ? 1'b0 : (grant_w ? 1'b1 : wtok_q));
    assign rtok_d = prog_mode ? start_tok : (pass_r ? 1'b0 : (grant_r ? 1'b1 : rtok_q));

    // Cascaded: one-cycle low pulse; otherwise the almost flag
    wire pin_d = cascade_en ? ~(pass_w | pass_r) : ~(ae_d | af_d);

    // ********************************************************
    // Parity and data path
    // ********************************************************
    wire par_gen = (prog_q.mode == ccf_pkg::CCF_PAR_GEN);
    wire par_chk = (prog_q.mode == ccf_pkg::CCF_PAR_CHK);
    wire lo_par = ^data_in[ccf_pkg::CCF_LO_MSB:ccf_pkg::CCF_LO_LSB];
    wire hi_par = ^data_in[ccf_pkg::CCF_HI_MSB:ccf_pkg::CCF_HI_LSB];
    wire lo_ok_n = ~^mem_rdata[ccf_pkg::CCF_PAR_LO:ccf_pkg::CCF_LO_LSB];
    wire hi_ok_n = ~^mem_rdata[ccf_pkg::CCF_PAR_HI:ccf_pkg::CCF_HI_LSB];

    assign wdata = {par_gen ? hi_par : data_in[ccf_pkg::CCF_PAR_HI],
                    data_in[ccf_pkg::CCF_HI_MSB:ccf_pkg::CCF_HI_LSB],
                    par_gen ? lo_par : data_in[ccf_pkg::CCF_PAR_LO],
                    data_in[ccf_pkg::CCF_LO_MSB:ccf_pkg::CCF_LO_LSB]};
    // Check mode turns bits 8 and 17 into error flags, high when good
    assign rd_word = {par_chk ? hi_ok_n : mem_rdata[ccf_pkg::CCF_PAR_HI],
                      mem_rdata[ccf_pkg::CCF_HI_MSB:ccf_pkg::CCF_HI_LSB],
                      par_chk ? lo_ok_n : mem_rdata[ccf_pkg::CCF_PAR_LO],
                      mem_rdata[ccf_pkg::CCF_LO_MSB:ccf_pkg::CCF_LO_LSB]};
    assign dout_d = prog_rd ? W'(prog_q) : (rd_do ? rd_word : data_out);

    ccf_store #(
        .W(W),
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_store (
        .ref_clk(ref_clk),
        .we(wr_do),
        .waddr(wptr_q[AW-1:0]),
        .wdata(wdata),
        .raddr(rptr_q[AW-1:0]),
        .rdata(mem_rdata)
    );

    // ********************************************************
    // Registers
    // ********************************************************
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wclk_q <= 1'b0;
            rclk_q <= 1'b0;
            xi_q <= 1'b1;
            wptr_q <= '0;
            rptr_q <= '0;
        end else begin
            wclk_q <= write_clock;
            rclk_q <= read_clock;
            xi_q <= cascade_in_n;
            wptr_q <= wptr_d;
            rptr_q <= rptr_d;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            empty_q <= 1'b1;
            ae_q <= 1'b1;
            full_q <= 1'b0;
            af_q <= 1'b0;
            wtok_q <= 1'b1;
            rtok_q <= 1'b1;
        end else begin
            empty_q <= empty_d;
            ae_q <= ae_d;
            full_q <= full_d;
            af_q <= af_d;
            wtok_q <= wtok_d;
            rtok_q <= rtok_d;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            prog_q <= ccf_pkg::CCF_PROG_RST;
        end else if (prog_wr) begin
            prog_q <= ccf_pkg::ccf_prog_t'(data_in);
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            data_out <= '0;
            data_oe <= 1'b0;
            empty_full_n <= 1'b0;
            half_full_flag <= 1'b0;
            almost_flag_cascade_out_n <= 1'b1;
        end else begin
            data_out <= dout_d;
            data_oe <= ~output_enable_n;
            empty_full_n <= ~(empty_d | full_d);
            half_full_flag <= hf_d;
            almost_flag_cascade_out_n <= pin_d;
        end
    end

    // ********************************************************
    // Assertions
    // ********************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    sequence s_write_taken;
        wr_edge && !write_enable_n && reset_program_n && !full_q && wtok_q;
    endsequence

    sequence s_retransmit;
        rd_edge && !retransmit_n && !cascade_en && reset_program_n;
    endsequence

    AST_WRITE_STEP: assert property (s_write_taken |=> wptr_q == $past(wptr_q) + ONE)
        else $error("taken write did not advance write pointer");

    AST_WRITE_BACK2BACK: assert property ((s_write_taken ##2 s_write_taken)
        |=> wptr_q == $past(wptr_q, 3) + ONE + ONE)
        else $error("back to back writes lost a word");

    AST_FULL_BLOCKS: assert property ((wr_req && reset_program_n && full_q)
        |=> wptr_q == $past(wptr_q))
        else $error("write accepted while full");

    AST_EMPTY_BLOCKS: assert property ((rd_req && reset_program_n && empty_q && !rt_do)
        |=> rptr_q == $past(rptr_q) && data_out == $past(data_out))
        else $error("read delivered while empty");

    AST_READ_DATA: assert property (rd_do |=> data_out[ccf_pkg::CCF_LO_MSB:0]
        == $past(mem_rdata[ccf_pkg::CCF_LO_MSB:0]))
        else $error("read word does not match storage");

    AST_PROG_WRITE: assert property (prog_wr |=> W'(prog_q) == $past(data_in)
        && wptr_q == '0)
        else $error("program write did not load program register");

    AST_RETRANSMIT: assert property ((s_retransmit and !wr_do)
        |=> rptr_q == '0 && wptr_q == $past(wptr_q))
        else $error("retransmit did not rewind read pointer only");

    AST_EMPTY_ON_READ_CLK: assert property ((!rd_edge && reset_program_n)
        |=> empty_q == $past(empty_q) && ae_q == $past(ae_q))
        else $error("empty flags moved without read clock edge");

    AST_FULL_ON_WRITE_CLK: assert property ((!wr_edge && reset_program_n)
        |=> full_q == $past(full_q) && half_full_flag == $past(half_full_flag))
        else $error("full side flags moved without write clock edge");

    AST_HALF_LEVEL: assert property ((wr_edge && reset_program_n)
        |=> half_full_flag == (cnt > HALF_CNT))
        else $error("half flag disagrees with fill count");

    AST_EF_PIN: assert property (##1 empty_full_n == ~(empty_q | full_q))
        else $error("empty or full pin disagrees with flags");

    AST_CASCADE_PULSE: assert property ((pass_w || pass_r)
        |=> !almost_flag_cascade_out_n ##1 almost_flag_cascade_out_n)
        else $error("cascade output pulse malformed");

    AST_OE_FLOAT: assert property (output_enable_n |=> !data_oe && rptr_q == $past(rptr_d))
        else $error("output enable mishandled");

    AST_FLAG_HOLD: assert property (
        ($changed(empty_q) && reset_program_n && $past(reset_program_n)) |=> $stable(empty_q))
        else $error("empty flag did not hold for a cycle");

endmodule // ccf_fifo

// [bench/ccf_partner.sv]
`timescale 1ns/1ps

// ********************************************************
// Producer and consumer on the two data ports
// ********************************************************
module ccf_partner #(
    parameter int W = ccf_pkg::CCF_WIDTH
) (
    input wire logic ref_clk,
    input wire logic [W-1:0] data_out,
    output logic write_clock,
    output logic write_enable_n,
    output logic [W-1:0] data_in,
    output logic read_clock,
    output logic read_enable_n,
    output logic retransmit_n
);
    logic [1:0] rph;

    initial begin
        write_clock = 1'b0;
        read_clock = 1'b0;
        rph = 2'h0;
        write_enable_n = 1'b1;
        read_enable_n = 1'b1;
        retransmit_n = 1'b1;
        data_in = '0;
    end

    // Free-running clocks, write period 2 and read period 3 cycles
    always @(negedge ref_clk) begin
        write_clock <= ~write_clock;
        rph <= (rph == 2'h2) ? 2'h0 : rph + 2'h1;
        read_clock <= (rph == 2'h2);
    end

    task automatic push(input logic [W-1:0] d);
        do @(negedge ref_clk); while (write_clock !== 1'b0);
        write_enable_n <= 1'b0;
        data_in <= d;
        @(negedge ref_clk);
        write_enable_n <= 1'b1;
        // Released bus shows the inverse, never the stale word
        data_in <= ~d;
    endtask

    task automatic pull(output logic [W-1:0] q);
        do @(negedge ref_clk); while (rph !== 2'h2);
        read_enable_n <= 1'b0;
        @(negedge ref_clk);
        read_enable_n <= 1'b1;
        @(negedge ref_clk);
        q = data_out;
    endtask

    // Both enables stay high while the replay strobe is low
    task automatic rewind();
        do @(negedge ref_clk); while (rph !== 2'h2);
        retransmit_n <= 1'b0;
        @(negedge ref_clk);
        retransmit_n <= 1'b1;
    endtask
endmodule // ccf_partner

// [bench/tb_cascadable_clocked_fifo_flags.sv]
`timescale 1ns/1ps

module tb_cascadable_clocked_fifo_flags;
    localparam int DEPTH = 512;
    localparam int W = ccf_pkg::CCF_WIDTH;
    localparam int LIMIT = 20000;
    logic ref_clk, rstn, output_enable_n, reset_program_n;
    logic write_clock, write_enable_n, read_clock, read_enable_n, retransmit_n;
    logic [W-1:0] data_in, data_out, q;
    logic data_oe, empty_full_n, half_full_flag, almost_flag_cascade_out_n;
    logic first_load_n, cascade_in_n, cascade_en;
    int errors = 0;
    int tests_run = 0;
    int cycles = 0;

    ccf_fifo #(.DEPTH(DEPTH)) ccf_fifo_i (
        .ref_clk(ref_clk), .rstn(rstn), .write_clock(write_clock),
        .write_enable_n(write_enable_n), .data_in(data_in), .read_clock(read_clock),
        .read_enable_n(read_enable_n), .output_enable_n(output_enable_n),
        .reset_program_n(reset_program_n), .retransmit_n(retransmit_n),
        .first_load_n(first_load_n), .cascade_in_n(cascade_in_n), .cascade_en(cascade_en),
        .data_out(data_out), .data_oe(data_oe), .empty_full_n(empty_full_n),
        .half_full_flag(half_full_flag),
        .almost_flag_cascade_out_n(almost_flag_cascade_out_n)
    );

    ccf_partner ccf_partner_i (
        .ref_clk(ref_clk), .data_out(data_out), .write_clock(write_clock),
        .write_enable_n(write_enable_n), .data_in(data_in), .read_clock(read_clock),
        .read_enable_n(read_enable_n), .retransmit_n(retransmit_n)
    );

    // ********************************************************
    // Clock, checks and closing
    // ********************************************************
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic report_and_stop();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            errors++;
            report_and_stop();
        end
    end

    task automatic chk_word(input logic [W-1:0] got, input logic [W-1:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({{(W-1){1'b0}}, got}, {{(W-1){1'b0}}, exp});
    endtask

    function automatic logic [W-1:0] pat(input int i);
        return {i[8:0], ~i[8:0]};
    endfunction

    function automatic logic [W-1:0] par(input logic [W-1:0] d);
        return {^d[16:9], d[16:9], ^d[7:0], d[7:0]};
    endfunction

    task automatic idle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic do_reset();
        @(negedge ref_clk);
        rstn = 1'b0;
        idle(3);
        rstn = 1'b1;
        idle(2);
    endtask

    // ********************************************************
    // Scenarios
    // ********************************************************
    task automatic t_basic();
        do_reset();
        chk_bit(empty_full_n, 1'b0);
        chk_bit(almost_flag_cascade_out_n, 1'b0);
        chk_bit(data_oe, 1'b0);
        ccf_partner_i.push(18'h3ffff);
        ccf_partner_i.push(18'h00000);
        ccf_partner_i.push(18'h2aaaa);
        idle(4);
        ccf_partner_i.pull(q);
        chk_word(q, 18'h3ffff);
        ccf_partner_i.pull(q);
        chk_word(q, 18'h00000);
        ccf_partner_i.pull(q);
        chk_word(q, 18'h2aaaa);
        ccf_partner_i.pull(q);
        chk_word(q, 18'h2aaaa);
        output_enable_n = 1'b0;
        idle(2);
        chk_bit(data_oe, 1'b1);
        chk_bit(empty_full_n, 1'b0);
        output_enable_n = 1'b1;
    endtask

    task automatic t_fill();
        do_reset();
        for (int i = 0; i < DEPTH; i++) begin
            ccf_partner_i.push(pat(i));
            idle(2);
            if (i == DEPTH / 2 - 1) chk_bit(half_full_flag, 1'b0);
            if (i == DEPTH / 2) chk_bit(half_full_flag, 1'b1);
            if (i == DEPTH - 10) chk_bit(almost_flag_cascade_out_n, 1'b1);
            if (i == DEPTH - 9) chk_bit(almost_flag_cascade_out_n, 1'b0);
        end
        chk_bit(empty_full_n, 1'b0);
        ccf_partner_i.push(18'h15555);
        for (int i = 0; i < DEPTH; i++) begin
            ccf_partner_i.pull(q);
            chk_word(q, pat(i));
            if (i == DEPTH - 10) chk_bit(almost_flag_cascade_out_n, 1'b1);
            if (i == DEPTH - 9) chk_bit(almost_flag_cascade_out_n, 1'b0);
        end
        chk_bit(empty_full_n, 1'b0);
        ccf_partner_i.pull(q);
        chk_word(q, pat(DEPTH - 1));
    endtask

    task automatic t_rewind();
        do_reset();
        for (int i = 0; i < 4; i++) ccf_partner_i.push(pat(i + 40));
        idle(4);
        for (int i = 0; i < 2; i++) begin
            ccf_partner_i.pull(q);
            chk_word(q, pat(i + 40));
        end
        ccf_partner_i.rewind();
        idle(3);
        for (int i = 0; i < 4; i++) begin
            ccf_partner_i.pull(q);
            chk_word(q, pat(i + 40));
        end
    endtask

    task automatic t_prog();
        do_reset();
        reset_program_n = 1'b0;
        ccf_partner_i.push(18'h10004);
        ccf_partner_i.pull(q);
        chk_word(q, 18'h10004);
        reset_program_n = 1'b1;
        idle(2);
        ccf_partner_i.push(18'h2a3c1);
        idle(4);
        ccf_partner_i.pull(q);
        chk_word(q, par(18'h2a3c1));
        reset_program_n = 1'b0;
        ccf_partner_i.push(18'h20008);
        reset_program_n = 1'b1;
        idle(2);
        ccf_partner_i.push(18'h00000);
        ccf_partner_i.push(18'h00001);
        idle(4);
        ccf_partner_i.pull(q);
        chk_word(q, 18'h20100);
        ccf_partner_i.pull(q);
        chk_word(q, 18'h20001);
    endtask

    // One-cycle low pulse from the previous device of the ring
    task automatic xi_pulse();
        cascade_in_n = 1'b0;
        idle(1);
        cascade_in_n = 1'b1;
    endtask

    task automatic t_cascade();
        do_reset();
        cascade_en = 1'b1;
        first_load_n = 1'b0;
        reset_program_n = 1'b0;
        idle(2);
        reset_program_n = 1'b1;
        for (int i = 0; i < DEPTH - 1; i++) ccf_partner_i.push(pat(i));
        chk_bit(almost_flag_cascade_out_n, 1'b1);
        ccf_partner_i.push(pat(DEPTH - 1));
        chk_bit(almost_flag_cascade_out_n, 1'b0);
        chk_bit(empty_full_n, 1'b0);
        idle(1);
        chk_bit(almost_flag_cascade_out_n, 1'b1);
        first_load_n = 1'b1;
        reset_program_n = 1'b0;
        idle(2);
        reset_program_n = 1'b1;
        ccf_partner_i.push(18'h0aaaa);
        xi_pulse();
        ccf_partner_i.push(18'h15555);
        xi_pulse();
        idle(4);
        ccf_partner_i.pull(q);
        chk_word(q, 18'h15555);
    endtask

    initial begin
        rstn = 1'b0;
        output_enable_n = 1'b1;
        reset_program_n = 1'b1;
        first_load_n = 1'b1;
        cascade_in_n = 1'b1;
        cascade_en = 1'b0;
        t_basic();
        t_fill();
        t_rewind();
        t_prog();
        t_cascade();
        report_and_stop();
    end
endmodule // tb_cascadable_clocked_fifo_flags
